/* File: rtl/lbr_defines.svh */
// constants of the display dma buffer address register bank
// assumes apb byte addresses: a register sits at four times its index
// What this block does
// RULE1 - end address joins upper half as bits 31:16, lower half as 15:0
// RULE2 - start address joins upper and lower halves into one 32-bit fetch address
// RULE3 - bit 0 of every lower start or end half reads zero, always
// RULE4 - software writes only even start and end byte addresses
// RULE5 - upper halves are fully read/write, undefined until written
// RULE6 - element index is a signed byte step in single and double modes
// RULE7 - frame index is a signed byte step used only in double mode
// RULE8 - buffer 1 frame index halves live at 0xDA and 0xF4
// RULE9 - buffer 2 frame index halves live at 0xDE and 0xF6
// RULE10 - buffer 2 has its own element index at 0xDC
// RULE11 - dual mode alternates buffers; single mode uses buffer 1 only
// RULE12 - mode 01 post-increment, 10 element index, 11 element plus frame, 00 reserved
// RULE13 - frame index is 32-bit signed, added in place of the element index on an advance that comes with a frame edge
`ifndef LBR_DEFINES_SVH
`define LBR_DEFINES_SVH

`define LBR_IDX_B1_START_LO 8'hC8
`define LBR_IDX_B1_START_HI 8'hCA
`define LBR_IDX_B1_END_LO   8'hCC
`define LBR_IDX_B1_END_HI   8'hCE
`define LBR_IDX_B2_START_LO 8'hD0
`define LBR_IDX_B2_START_HI 8'hD2
`define LBR_IDX_B2_END_LO   8'hD4
`define LBR_IDX_B2_END_HI   8'hD6
`define LBR_IDX_B1_ELEM     8'hD8
`define LBR_IDX_B1_FRAME_LO 8'hDA
`define LBR_IDX_B2_ELEM     8'hDC
`define LBR_IDX_B2_FRAME_LO 8'hDE
`define LBR_IDX_B1_FRAME_HI 8'hF4
`define LBR_IDX_B2_FRAME_HI 8'hF6
`define LBR_IDX_CONFIG      8'hF8
`define LBR_IDX_FETCH_LO    8'hFA
`define LBR_IDX_FETCH_HI    8'hFC
`define LBR_IDX_STATUS      8'hFE

`define LBR_CFG_DUAL_BIT    0
`define LBR_CFG_MODE1_LSB   1
`define LBR_CFG_MODE2_LSB   3
`define LBR_MODE_RESET      2'h1
`define LBR_ELEM_BYTES      2

`endif

/* File: rtl/lbr_pkg.sv */
// types shared by the buffer address register bank
// assumes nothing beyond a systemverilog compiler
package lbr_pkg;
   typedef enum logic [1:0] {
      LBR_AM_RSVD    = 2'h0,
      LBR_AM_POSTINC = 2'h1,
      LBR_AM_SINGLE  = 2'h2,
      LBR_AM_DOUBLE  = 2'h3
   } lbr_amode_t;
endpackage : lbr_pkg

/* File: rtl/lbr_addr_step.sv */
// next fetch address from the current one and the active buffer's steps
// assumes steps are stable while an advance is applied
`include "lbr_defines.svh"

module lbr_addr_step #(
   parameter int ELEM_BYTES = `LBR_ELEM_BYTES
) (
   input  wire logic [31:0]        cur_addr,
   input  wire lbr_pkg::lbr_amode_t mode,
   input  wire logic [15:0]        elem_step,
   input  wire logic [31:0]        frame_step,
   input  wire logic               frame_edge,
   output logic      [31:0]        step_addr
);
   import lbr_pkg::*;

   logic [31:0] elem_ext;

   // element index is a signed byte offset
   assign elem_ext = {{16{elem_step[15]}}, elem_step}; // RULE6

   always_comb begin
      case (mode) // RULE12
         LBR_AM_POSTINC: step_addr = cur_addr + 32'(ELEM_BYTES);
         LBR_AM_SINGLE:  step_addr = cur_addr + elem_ext; // RULE6 RULE7
         LBR_AM_DOUBLE:  step_addr = cur_addr + (frame_edge ? frame_step : elem_ext); // RULE13
         // reserved code: address holds rather than wander
         default:        step_addr = cur_addr;
      endcase
   end
endmodule : lbr_addr_step

/* File: rtl/lbr_regs.sv */
// buffer start/end addresses and signed steps of the display dma channel
// apb slave plus the fetch address walker that uses those values
// assumes fetch control pulses come from the channel on the same clock
//
// The APB register port was chosen for this implementation.
`include "lbr_defines.svh"

module lbr_regs #(
   parameter int ADDR_W     = 10,
   parameter int ELEM_BYTES = `LBR_ELEM_BYTES
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata_ff,
   output logic                   pready_ff,
   output logic                   pslverr_ff,
   input  wire logic              fetch_start,
   input  wire logic              elem_adv,
   input  wire logic              frame_edge,
   input  wire logic              block_done,
   output logic      [31:0]       fetch_addr_ff,
   output logic                   active_buf_ff,
   output logic                   end_hit_ff,
   output lbr_pkg::lbr_amode_t    active_mode_ff
);
   import lbr_pkg::*;

   // data halves are left without reset: their content is undefined until written
   logic [15:0] start_hi [2];
   logic [14:0] start_lo [2];
   logic [15:0] end_hi   [2];
   logic [14:0] end_lo   [2];
   logic [15:0] elem_idx [2];
   logic [15:0] frame_hi [2];
   logic [15:0] frame_lo [2];

   logic             dual_ff;
   lbr_amode_t       mode_ff [2];
   logic [7:0]       idx;
   logic             aligned;
   logic             hit;
   logic             wr_en;
   logic [31:0]      rd_val;
   logic [31:0]      step_addr;
   logic [31:0]      nxt_addr;
   logic             nxt_buf;
   logic [31:0]      nxt_end;

   // even byte address from an upper half and the stored bits 15:1
   function automatic logic [31:0] join_addr(input logic [15:0] hi, input logic [14:0] lo);
      join_addr = {hi, lo, 1'b0}; // RULE1 RULE2 RULE3
   endfunction : join_addr

   assign idx     = paddr[9:2];
   assign aligned = (paddr[1:0] == 2'h0);

   always_comb begin
      case (idx)
         `LBR_IDX_B1_START_LO, `LBR_IDX_B1_START_HI,
         `LBR_IDX_B1_END_LO,   `LBR_IDX_B1_END_HI,
         `LBR_IDX_B2_START_LO, `LBR_IDX_B2_START_HI,
         `LBR_IDX_B2_END_LO,   `LBR_IDX_B2_END_HI,
         `LBR_IDX_B1_ELEM,     `LBR_IDX_B2_ELEM,
         `LBR_IDX_B1_FRAME_LO, `LBR_IDX_B1_FRAME_HI,
         `LBR_IDX_B2_FRAME_LO, `LBR_IDX_B2_FRAME_HI,
         `LBR_IDX_CONFIG,      `LBR_IDX_FETCH_LO,
         `LBR_IDX_FETCH_HI,    `LBR_IDX_STATUS: hit = aligned;
         default:                               hit = 1'b0;
      endcase
   end

   // write lands only on the access edge where pready is sampled high
   assign wr_en = psel && penable && pready_ff && pwrite && hit;

   // apb handshake: no wait state, answer prepared in the setup cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= psel && !penable;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (psel && !penable) begin
         prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
         pslverr_ff <= !hit;
      end else if (pready_ff) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
   end

   // narrow registers sit in the low half; bits above read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (idx)
         `LBR_IDX_B1_START_LO: rd_val[15:0] = {start_lo[0], 1'b0}; // RULE3
         `LBR_IDX_B1_START_HI: rd_val[15:0] = start_hi[0]; // RULE5
         `LBR_IDX_B1_END_LO:   rd_val[15:0] = {end_lo[0], 1'b0}; // RULE3
         `LBR_IDX_B1_END_HI:   rd_val[15:0] = end_hi[0]; // RULE5
         `LBR_IDX_B2_START_LO: rd_val[15:0] = {start_lo[1], 1'b0}; // RULE3
         `LBR_IDX_B2_START_HI: rd_val[15:0] = start_hi[1]; // RULE5
         `LBR_IDX_B2_END_LO:   rd_val[15:0] = {end_lo[1], 1'b0}; // RULE3
         `LBR_IDX_B2_END_HI:   rd_val[15:0] = end_hi[1]; // RULE5
         `LBR_IDX_B1_ELEM:     rd_val[15:0] = elem_idx[0];
         `LBR_IDX_B2_ELEM:     rd_val[15:0] = elem_idx[1]; // RULE10
         `LBR_IDX_B1_FRAME_LO: rd_val[15:0] = frame_lo[0]; // RULE8
         `LBR_IDX_B1_FRAME_HI: rd_val[15:0] = frame_hi[0]; // RULE8
         `LBR_IDX_B2_FRAME_LO: rd_val[15:0] = frame_lo[1]; // RULE9
         `LBR_IDX_B2_FRAME_HI: rd_val[15:0] = frame_hi[1]; // RULE9
         `LBR_IDX_CONFIG:      rd_val[4:0]  = {mode_ff[1], mode_ff[0], dual_ff};
         `LBR_IDX_FETCH_LO:    rd_val[15:0] = fetch_addr_ff[15:0];
         `LBR_IDX_FETCH_HI:    rd_val[15:0] = fetch_addr_ff[31:16];
         `LBR_IDX_STATUS:      rd_val[1:0]  = {end_hit_ff, active_buf_ff};
         default:              rd_val       = 32'h0000_0000;
      endcase
   end

   // address and step storage
   always_ff @(posedge clock) begin
      if (wr_en) begin
         case (idx)
            `LBR_IDX_B1_START_LO: start_lo[0] <= pwdata[15:1]; // RULE2 RULE3
            `LBR_IDX_B1_START_HI: start_hi[0] <= pwdata[15:0]; // RULE5
            `LBR_IDX_B1_END_LO:   end_lo[0]   <= pwdata[15:1]; // RULE1 RULE3
            `LBR_IDX_B1_END_HI:   end_hi[0]   <= pwdata[15:0]; // RULE5
            `LBR_IDX_B2_START_LO: start_lo[1] <= pwdata[15:1]; // RULE2 RULE3
            `LBR_IDX_B2_START_HI: start_hi[1] <= pwdata[15:0]; // RULE5
            `LBR_IDX_B2_END_LO:   end_lo[1]   <= pwdata[15:1]; // RULE1 RULE3
            `LBR_IDX_B2_END_HI:   end_hi[1]   <= pwdata[15:0]; // RULE5
            `LBR_IDX_B1_ELEM:     elem_idx[0] <= pwdata[15:0];
            `LBR_IDX_B2_ELEM:     elem_idx[1] <= pwdata[15:0]; // RULE10
            `LBR_IDX_B1_FRAME_LO: frame_lo[0] <= pwdata[15:0]; // RULE8
            `LBR_IDX_B1_FRAME_HI: frame_hi[0] <= pwdata[15:0]; // RULE8
            `LBR_IDX_B2_FRAME_LO: frame_lo[1] <= pwdata[15:0]; // RULE9
            `LBR_IDX_B2_FRAME_HI: frame_hi[1] <= pwdata[15:0]; // RULE9
            default: ;
         endcase
      end
   end

   // buffer mode and per-buffer addressing mode
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dual_ff    <= 1'b0;
         mode_ff[0] <= lbr_amode_t'(`LBR_MODE_RESET);
         mode_ff[1] <= lbr_amode_t'(`LBR_MODE_RESET);
      end else if (wr_en && idx == `LBR_IDX_CONFIG) begin
         dual_ff    <= pwdata[`LBR_CFG_DUAL_BIT];
         mode_ff[0] <= lbr_amode_t'(pwdata[`LBR_CFG_MODE1_LSB +: 2]); // RULE12
         mode_ff[1] <= lbr_amode_t'(pwdata[`LBR_CFG_MODE2_LSB +: 2]); // RULE12
      end
   end

   lbr_addr_step #(
      .ELEM_BYTES (ELEM_BYTES)
   ) u_step (
      .cur_addr   (fetch_addr_ff),
      .mode       (mode_ff[active_buf_ff]),
      .elem_step  (elem_idx[active_buf_ff]), // RULE6 RULE10
      .frame_step ({frame_hi[active_buf_ff], frame_lo[active_buf_ff]}), // RULE13
      .frame_edge (frame_edge),
      .step_addr  (step_addr)
   );

   // start outranks block end, block end outranks a plain advance
   always_comb begin
      nxt_buf  = active_buf_ff;
      nxt_addr = fetch_addr_ff;
      if (fetch_start) begin
         nxt_buf  = 1'b0;
         nxt_addr = join_addr(start_hi[0], start_lo[0]); // RULE2
      end else if (block_done) begin
         nxt_buf  = dual_ff ? !active_buf_ff : 1'b0; // RULE11
         nxt_addr = join_addr(start_hi[nxt_buf], start_lo[nxt_buf]);
      end else if (elem_adv) begin
         nxt_addr = step_addr;
      end
      nxt_end = join_addr(end_hi[nxt_buf], end_lo[nxt_buf]); // RULE1
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fetch_addr_ff <= 32'h0000_0000;
         active_buf_ff <= 1'b0;
      end else begin
         fetch_addr_ff <= nxt_addr;
         active_buf_ff <= nxt_buf; // RULE11
      end
   end

   // end compare lags the channel by nothing: it is taken on the same edge
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         end_hit_ff     <= 1'b0;
         active_mode_ff <= lbr_amode_t'(`LBR_MODE_RESET);
      end else begin
         end_hit_ff     <= (nxt_addr == nxt_end); // RULE1
         active_mode_ff <= mode_ff[nxt_buf];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic plain_adv;
   assign plain_adv = elem_adv && !fetch_start && !block_done;

   a_start_load_value: assert property ( // RULE2
      fetch_start |=> fetch_addr_ff == {$past(start_hi[0]), $past(start_lo[0]), 1'b0}
   ) else $error("fetch start did not load buffer 1 start address");

   a_start_even_bit: assert property ( // RULE3
      (fetch_start || block_done) |=> fetch_addr_ff[0] == 1'b0
   ) else $error("loaded start address is odd");

   a_end_hit_match: assert property ( // RULE1
      (end_hit_ff && !$past(wr_en)) |->
         fetch_addr_ff == {end_hi[active_buf_ff], end_lo[active_buf_ff], 1'b0}
   ) else $error("end hit without matching end address");

   a_upper_write_back: assert property ( // RULE5
      (wr_en && idx == `LBR_IDX_B2_END_HI) |=> end_hi[1] == $past(pwdata[15:0])
   ) else $error("upper half did not take written value");

   a_elem_step_add: assert property ( // RULE6
      (plain_adv && !frame_edge && mode_ff[active_buf_ff] == LBR_AM_DOUBLE) |=>
         fetch_addr_ff == $past(fetch_addr_ff) + {{16{$past(elem_idx[active_buf_ff][15])}},
                                                  $past(elem_idx[active_buf_ff])}
   ) else $error("element index step wrong");

   a_single_no_frame: assert property ( // RULE7
      (plain_adv && frame_edge && mode_ff[active_buf_ff] == LBR_AM_SINGLE) |=>
         fetch_addr_ff == $past(fetch_addr_ff) + {{16{$past(elem_idx[active_buf_ff][15])}},
                                                  $past(elem_idx[active_buf_ff])}
   ) else $error("single index used the frame index");

   a_frame_step_add: assert property ( // RULE13
      (plain_adv && frame_edge && mode_ff[active_buf_ff] == LBR_AM_DOUBLE) |=>
         fetch_addr_ff == $past(fetch_addr_ff)
                          + {$past(frame_hi[active_buf_ff]), $past(frame_lo[active_buf_ff])}
   ) else $error("frame index step wrong");

   a_frame1_split: assert property ( // RULE8
      (wr_en && idx == `LBR_IDX_B1_FRAME_HI) |=>
         frame_hi[0] == $past(pwdata[15:0]) && $stable(frame_lo[0])
   ) else $error("buffer 1 upper frame half misplaced");

   a_frame2_split: assert property ( // RULE9
      (wr_en && idx == `LBR_IDX_B2_FRAME_LO) |=>
         frame_lo[1] == $past(pwdata[15:0]) && $stable(frame_hi[1])
   ) else $error("buffer 2 lower frame half misplaced");

   a_elem2_separate: assert property ( // RULE10
      (wr_en && idx == `LBR_IDX_B2_ELEM) |=>
         elem_idx[1] == $past(pwdata[15:0]) && $stable(elem_idx[0])
   ) else $error("buffer 2 element index not separate");

   a_dual_alternate: assert property ( // RULE11
      (block_done && !fetch_start) |=>
         active_buf_ff == ($past(dual_ff) ? !$past(active_buf_ff) : 1'b0)
   ) else $error("buffer alternation wrong");

   a_mode_code_step: assert property ( // RULE12
      (plain_adv && mode_ff[active_buf_ff] == LBR_AM_POSTINC) |=>
         fetch_addr_ff == $past(fetch_addr_ff) + 32'(ELEM_BYTES)
   ) else $error("post-increment step wrong");

   a_mode_rsvd_hold: assert property ( // RULE12
      (plain_adv && mode_ff[active_buf_ff] == LBR_AM_RSVD) |=> $stable(fetch_addr_ff)
   ) else $error("reserved mode moved the address");

   a_apb_ready_once: assert property (
      (psel && !penable) |=> pready_ff ##1 !pready_ff
   ) else $error("pready not a single cycle after setup");

endmodule : lbr_regs

/* File: verif/lcd_dma_buffer_address_regs_bench.sv */
// self-checking bench for the buffer address register bank and its fetch walker
// assumes the bank answers apb within a few cycles and fetch control acts in one
`include "lbr_defines.svh"

module lcd_dma_buffer_address_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clock       = 1'b0;
   logic        rst_n       = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [9:0]  paddr       = 10'h000;
   logic [31:0] pwdata      = 32'h0000_0000;
   logic        fetch_start = 1'b0;
   logic        elem_adv    = 1'b0;
   logic        frame_edge  = 1'b0;
   logic        block_done  = 1'b0;
   logic [31:0] prdata_ff;
   logic [31:0] fetch_addr_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        active_buf_ff;
   logic        end_hit_ff;
   logic [1:0]  active_mode_ff;
   int          n_fail      = 0;
   int          n_checks    = 0;
   logic [33:0] exp_q[$];
   logic [33:0] exp_e;
   logic [35:0] fq[$];
   logic [35:0] f_e;
   // buffer 2 upper frame half before its lower one, so no half is unwritten when its pair lands
   logic [7:0]  reg_idx[14] = '{`LBR_IDX_B1_START_LO, `LBR_IDX_B1_START_HI, `LBR_IDX_B1_END_LO,
      `LBR_IDX_B1_END_HI, `LBR_IDX_B2_START_LO, `LBR_IDX_B2_START_HI, `LBR_IDX_B2_END_LO,
      `LBR_IDX_B2_END_HI, `LBR_IDX_B1_ELEM, `LBR_IDX_B1_FRAME_LO, `LBR_IDX_B2_ELEM,
      `LBR_IDX_B2_FRAME_HI, `LBR_IDX_B2_FRAME_LO, `LBR_IDX_B1_FRAME_HI};
   logic [15:0] reg_msk[14] = '{16'hFFFE, 16'hFFFF, 16'hFFFE, 16'hFFFF, 16'hFFFE, 16'hFFFF,
      16'hFFFE, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   logic [31:0] reg_val[14];
   logic [31:0] s1, e1, s2, e2, f1, f2, a;
   logic [15:0] el1, el2;

   lbr_regs #(.ADDR_W(10), .ELEM_BYTES(`LBR_ELEM_BYTES)) u_dut (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
      .pslverr_ff(pslverr_ff), .fetch_start(fetch_start), .elem_adv(elem_adv),
      .frame_edge(frame_edge), .block_done(block_done), .fetch_addr_ff(fetch_addr_ff),
      .active_buf_ff(active_buf_ff), .end_hit_ff(end_hit_ff), .active_mode_ff(active_mode_ff));

   always #5 clock = ~clock;

   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; the note of the expected answer goes to the monitor
   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, input logic err,
            input logic [31:0] rd);
      exp_q.push_back({~wr, err, rd});
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clock);
      end while (pready_ff !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // sampled at the edge that completes the transfer, before its updates land
   always @(posedge clock) begin
      if (psel === 1'b1 && penable === 1'b1 && pready_ff === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_fail++;
         end else begin
            exp_e = exp_q.pop_front();
            check(32'(pslverr_ff), 32'(exp_e[32]));
            if (exp_e[33]) check(prdata_ff, exp_e[31:0]);
         end
      end
   end

   task ctl(input logic fs, input logic ea, input logic fe, input logic bd);
      @(posedge clock);
      fetch_start <= fs;
      elem_adv    <= ea;
      frame_edge  <= fe;
      block_done  <= bd;
      @(posedge clock);
      fetch_start <= 1'b0;
      elem_adv    <= 1'b0;
      frame_edge  <= 1'b0;
      block_done  <= 1'b0;
      #1;
   endtask : ctl

   task expect_fetch(input logic [31:0] ea, input logic b, input logic [1:0] m,
                     input logic [31:0] ee);
      fq.push_back({ea, b, m, ea == ee});
   endtask : expect_fetch

   // fetch outputs settle on the pulse edge and stand until the next pulse
   always @(negedge clock) begin
      if (fq.size() != 0) begin
         f_e = fq.pop_front();
         check(fetch_addr_ff, f_e[35:4]);
         check(32'(active_buf_ff), 32'(f_e[3]));
         check(32'(active_mode_ff), 32'(f_e[2:1]));
         check(32'(end_hit_ff), 32'(f_e[0]));
      end
   end

   task wr32(input logic [7:0] lo, input logic [7:0] hi, input logic [31:0] v);
      apb(1'b1, lo, {16'h0000, v[15:0]}, 1'b0, 32'h0000_0000);
      apb(1'b1, hi, {16'h0000, v[31:16]}, 1'b0, 32'h0000_0000);
   endtask : wr32

   task do_reset(input int cyc);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (cyc) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      check(fetch_addr_ff, 32'h0000_0000);
      check(32'({active_buf_ff, pready_ff, pslverr_ff}), 32'h0000_0000);
      check(32'(active_mode_ff), 32'h0000_0001);
      apb(1'b0, `LBR_IDX_CONFIG, 32'h0000_0000, 1'b0, 32'h0000_000A);
   endtask : do_reset

   function automatic logic [31:0] step(input logic [1:0] m, input logic fe,
                                        input logic [15:0] el, input logic [31:0] fr);
      case (m)
         2'h1:    return 32'(`LBR_ELEM_BYTES);
         2'h2:    return {{16{el[15]}}, el};
         2'h3:    return fe ? fr : {{16{el[15]}}, el};
         default: return 32'h0000_0000;
      endcase
   endfunction : step

   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h9f04_20dc));
      do_reset(16);
      // all written first, so an alias between two places shows on readback
      foreach (reg_idx[i]) begin
         reg_val[i] = $urandom() | 32'h0000_0001;
         apb(1'b1, reg_idx[i], reg_val[i], 1'b0, 32'h0000_0000);
      end
      foreach (reg_idx[i]) begin
         a = {16'h0000, reg_val[i][15:0] & reg_msk[i]};
         apb(1'b0, reg_idx[i], 32'h0, 1'b0, a);
      end
      apb(1'b0, 8'h10, 32'h0000_0000, 1'b1, 32'h0000_0000);
      apb(1'b1, 8'h40, $urandom(), 1'b1, 32'h0000_0000);
      // software only ever hands over even start and end addresses
      s1 = $urandom() & 32'hFFFF_FFFE;
      e1 = s1 + 32'h0000_0002;
      s2 = $urandom() & 32'hFFFF_FFFE;
      e2 = s2 + 32'h0000_0100;
      f1 = $urandom();
      f2 = $urandom();
      el1 = 16'($urandom());
      el2 = 16'($urandom());
      wr32(`LBR_IDX_B1_START_LO, `LBR_IDX_B1_START_HI, s1);
      wr32(`LBR_IDX_B1_END_LO, `LBR_IDX_B1_END_HI, e1);
      wr32(`LBR_IDX_B2_START_LO, `LBR_IDX_B2_START_HI, s2);
      wr32(`LBR_IDX_B2_END_LO, `LBR_IDX_B2_END_HI, e2);
      wr32(`LBR_IDX_B1_FRAME_LO, `LBR_IDX_B1_FRAME_HI, f1);
      wr32(`LBR_IDX_B2_FRAME_LO, `LBR_IDX_B2_FRAME_HI, f2);
      apb(1'b1, `LBR_IDX_B1_ELEM, {16'h0000, el1}, 1'b0, 32'h0000_0000);
      apb(1'b1, `LBR_IDX_B2_ELEM, {16'h0000, el2}, 1'b0, 32'h0000_0000);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `LBR_IDX_CONFIG, 32'h0000_0008 | 32'(m << 1), 1'b0, 32'h0000_0000);
         ctl(1'b1, 1'b0, 1'b0, 1'b0);
         a = s1;
         expect_fetch(a, 1'b0, 2'(m), e1);
         ctl(1'b0, 1'b1, 1'b0, 1'b0);
         a = a + step(2'(m), 1'b0, el1, f1);
         expect_fetch(a, 1'b0, 2'(m), e1);
         ctl(1'b0, 1'b1, 1'b1, 1'b0);
         a = a + step(2'(m), 1'b1, el1, f1);
         expect_fetch(a, 1'b0, 2'(m), e1);
      end
      // the read-only fetch low place ignores a write
      apb(1'b1, `LBR_IDX_FETCH_LO, ~a, 1'b0, 32'h0000_0000);
      apb(1'b0, `LBR_IDX_FETCH_LO, 32'h0, 1'b0, {16'h0000, a[15:0]});
      apb(1'b0, `LBR_IDX_FETCH_HI, 32'h0, 1'b0, {16'h0000, a[31:16]});
      apb(1'b0, `LBR_IDX_STATUS, 32'h0, 1'b0, {30'h0, a == e1, 1'b0});
      // dual: buffer 1 post-increment, buffer 2 double index
      apb(1'b1, `LBR_IDX_CONFIG, 32'h0000_001B, 1'b0, 32'h0000_0000);
      ctl(1'b1, 1'b0, 1'b0, 1'b0);
      expect_fetch(s1, 1'b0, 2'h1, e1);
      ctl(1'b0, 1'b0, 1'b0, 1'b1);
      expect_fetch(s2, 1'b1, 2'h3, e2);
      ctl(1'b0, 1'b1, 1'b1, 1'b0);
      a = s2 + f2;
      expect_fetch(a, 1'b1, 2'h3, e2);
      ctl(1'b0, 1'b1, 1'b0, 1'b0);
      a = a + {{16{el2[15]}}, el2};
      expect_fetch(a, 1'b1, 2'h3, e2);
      ctl(1'b0, 1'b0, 1'b0, 1'b1);
      expect_fetch(s1, 1'b0, 2'h1, e1);
      // single: end of block returns to buffer 1
      apb(1'b1, `LBR_IDX_CONFIG, 32'h0000_001A, 1'b0, 32'h0000_0000);
      ctl(1'b0, 1'b1, 1'b0, 1'b0);
      expect_fetch(s1 + 32'(`LBR_ELEM_BYTES), 1'b0, 2'h1, e1);
      ctl(1'b0, 1'b0, 1'b0, 1'b1);
      expect_fetch(s1, 1'b0, 2'h1, e1);
      // start outranks an advance on the same edge; in single mode end of block would also reload s1, so it is not told apart
      ctl(1'b1, 1'b1, 1'b1, 1'b1);
      expect_fetch(s1, 1'b0, 2'h1, e1);
      do_reset(2);
      finish_test();
   end
endmodule : lcd_dma_buffer_address_regs_bench
